// ### logic/sdram_refresh_pkg.sv
// shared constants for the refresh and self-refresh link
package sdram_refresh_pkg;
  // timing in ns as printed or chosen, cycle counts derived at 50 mhz
  localparam int unsigned clk_period_ns = 20;
  localparam int unsigned trefi_ns = 7800;
  localparam int unsigned trfc_ns = 260;
  localparam int unsigned trp_ns = 14;
  localparam int unsigned txs_ns = 270;
  localparam int unsigned tcke_ns = 5;
  localparam int unsigned tckesr_ns = 10;
  localparam int unsigned txsdll_cycles = 512;
  // least times round up, tckesr with one cycle added, except tcke, which rounds down to at least one; longest times round down
  localparam int unsigned trfc_cycles = (trfc_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned trp_cycles = (trp_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned txs_cycles = (txs_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned tckesr_cycles = (tckesr_ns + clk_period_ns - 1) / clk_period_ns + 1;
  localparam int unsigned tcke_cycles = (tcke_ns / clk_period_ns) > 0 ?
                                        (tcke_ns / clk_period_ns) : 1;
  localparam int unsigned trefi_cycles = trefi_ns / clk_period_ns;
  // refresh credit limits
  localparam int max_postponed = 8;
  localparam int max_pulled_in = 8;
  // burst select values on the burst-chop address bit
  localparam logic burst_chop4 = 1'b0;
  localparam logic burst_len8 = 1'b1;
  // command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] cmd_nop = 4'h7;
  localparam logic [3:0] cmd_refresh = 4'h1;
  localparam logic [3:0] cmd_read = 4'h5;
  localparam logic [3:0] cmd_write = 4'h4;
  localparam logic [3:0] cmd_precharge = 4'h2;
  localparam logic [3:0] cmd_activate = 4'h3;
  // device states
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_refresh = 3'b001,
    st_selfref = 3'b011,
    st_exit = 3'b010
  } dev_state_e;
endpackage : sdram_refresh_pkg

// ### logic/sdram_cmd_if.sv
// command link between controller and device
`timescale 1ns/1ps
interface sdram_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic odt;
  logic [15:0] addr;
  logic wr_err;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, addr, output wr_err);
  modport dev (input cs_n, ras_n, cas_n, we_n, cke, odt, addr, wr_err);
endinterface : sdram_cmd_if

// ### logic/sdram_refresh_dev.sv
// device end: command decode, refresh and self-refresh behaviour
`timescale 1ns/1ps
// Rules from the document
// [R1] a12 picks chop four or eight beats
// [R2] setup/hold error spoils only addressed location
// [R3] strobe errors spoil only that write
// [R4] refresh decoded from cs ras cas low
// [R5] refresh only after all banks precharged
// [R6] internal row counter, banks idle afterwards
// [R7] only nop until refresh cycle ends
// [R8] refreshes issued every refresh interval average
// [R9] at most eight refreshes postponed
// [R10] eight pulled-in refreshes earn credit, no more
// [R11] postponed refreshes done before self-refresh
// [R12] self-refresh entry decoded with cke low
// [R13] termination off before self-refresh entry
// [R14] cke held low, minimum residency kept
// [R15] dll off on entry, reset on exit
// [R16] ignore inputs, refresh internally within tcke
// [R17] clock stable before raising cke
// [R18] exit waits tXS or tXSDLL
// [R19] nop only and cke high during exit
// [R20] extra refresh before self-refresh re-entry
// [R21] zq calibration after exit when needed; no zq calibration is issued here
// [R22] controller tracks bounded signed refresh credit
module sdram_refresh_dev #(
  parameter int unsigned row_w = 16,
  parameter int unsigned sr_timer = sdram_refresh_pkg::trefi_cycles
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command link
  sdram_cmd_if.dev link,
  // user side status
  output logic busy_q,
  output logic in_selfref_q,
  output logic dll_locked_q,
  output logic [row_w-1:0] refresh_row_q,
  output logic refresh_pulse_q,
  output logic burst8_q,
  output logic burst_valid_q,
  output logic [9:0] col_q,
  output logic corrupt_q,
  output logic [9:0] corrupt_col_q,
  output logic protocol_err_q
);
  initial begin
    if (row_w < 1 || row_w > 16) $error("row_w out of range");
    if (sr_timer < 1) $error("sr_timer must be positive");
  end

  // previous cke for edge detection
  logic cke_prev_q;
  sdram_refresh_pkg::dev_state_e state_q;
  sdram_refresh_pkg::dev_state_e state_d;
  logic [15:0] timer_q;
  logic [15:0] timer_d;
  logic [15:0] sr_cnt_q;

  // command decode
  wire [3:0] cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  wire cmd_is_nop = link.cs_n | (cmd == sdram_refresh_pkg::cmd_nop);
  wire is_ref = (cmd == sdram_refresh_pkg::cmd_refresh) && link.cke && cke_prev_q; // [R4]
  wire is_sre = (cmd == sdram_refresh_pkg::cmd_refresh) && !link.cke && cke_prev_q; // [R12]
  wire is_rw = (cmd == sdram_refresh_pkg::cmd_read || cmd == sdram_refresh_pkg::cmd_write) &&
               link.cke;
  wire is_srx = link.cke && !cke_prev_q && cmd_is_nop; // [R18]
  wire timer_done = (timer_q == 16'h0000);
  wire sr_tick = (sr_cnt_q == 16'h0000);
  wire non_nop = !cmd_is_nop && link.cke;

  // next state
  always_comb begin
    state_d = state_q;
    timer_d = timer_done ? 16'h0000 : timer_q - 16'h0001;
    case (state_q)
      sdram_refresh_pkg::st_idle: begin
        if (is_ref) begin
          state_d = sdram_refresh_pkg::st_refresh;
          timer_d = 16'(sdram_refresh_pkg::trfc_cycles - 1); // [R7]
        end else if (is_sre) begin
          state_d = sdram_refresh_pkg::st_selfref;
          timer_d = 16'(sdram_refresh_pkg::tckesr_cycles); // [R14]
        end
      end
      sdram_refresh_pkg::st_refresh: begin
        if (timer_done) begin
          state_d = sdram_refresh_pkg::st_idle; // [R6]
        end
      end
      sdram_refresh_pkg::st_selfref: begin
        // only cke and a nop command are watched here [R16]
        if (is_srx) begin
          state_d = sdram_refresh_pkg::st_exit;
          timer_d = 16'(sdram_refresh_pkg::txsdll_cycles - 1); // [R18]
        end
      end
      sdram_refresh_pkg::st_exit: begin
        if (is_sre) begin
          state_d = sdram_refresh_pkg::st_selfref;
          timer_d = 16'(sdram_refresh_pkg::tckesr_cycles);
        end else if (timer_done) begin
          state_d = sdram_refresh_pkg::st_idle;
        end
      end
      default: state_d = sdram_refresh_pkg::st_idle;
    endcase
  end

  // state and timers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= sdram_refresh_pkg::st_idle;
      timer_q <= 16'h0000;
      // matches the idle-high level of cke so no false exit edge follows reset
      cke_prev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      cke_prev_q <= link.cke;
    end
  end

  // internal self-refresh timer, first refresh right after entry
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sr_cnt_q <= 16'h0000;
    end else if (state_q != sdram_refresh_pkg::st_selfref) begin
      sr_cnt_q <= 16'h0000; // [R16]
    end else if (sr_tick) begin
      sr_cnt_q <= 16'(sr_timer - 1);
    end else begin
      sr_cnt_q <= sr_cnt_q - 16'h0001;
    end
  end

  // internal row counter advances on each refresh, address ignored
  wire do_refresh = is_ref && state_q == sdram_refresh_pkg::st_idle ||
                    (state_q == sdram_refresh_pkg::st_selfref && sr_tick);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      refresh_row_q <= '0;
      refresh_pulse_q <= 1'b0;
    end else begin
      refresh_pulse_q <= do_refresh;
      if (do_refresh) begin
        refresh_row_q <= refresh_row_q + 1'b1; // [R6]
      end
    end
  end

  // status and dll handling
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      in_selfref_q <= 1'b0;
      dll_locked_q <= 1'b1;
    end else begin
      busy_q <= state_d != sdram_refresh_pkg::st_idle;
      in_selfref_q <= state_d == sdram_refresh_pkg::st_selfref;
      // off in self-refresh, relocks after the dll exit delay [R15]
      dll_locked_q <= state_d == sdram_refresh_pkg::st_idle ||
                      state_d == sdram_refresh_pkg::st_refresh;
    end
  end

  // burst decode; a12 is never a column bit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      burst8_q <= 1'b0;
      burst_valid_q <= 1'b0;
      col_q <= 10'h000;
      corrupt_q <= 1'b0;
      corrupt_col_q <= 10'h000;
    end else begin
      burst_valid_q <= is_rw && state_q == sdram_refresh_pkg::st_idle;
      if (is_rw) begin
        burst8_q <= link.addr[12] == sdram_refresh_pkg::burst_len8; // [R1]
        col_q <= link.addr[9:0];
      end
      // a strobe error marks only the addressed column, no lockup [R2] [R3]
      corrupt_q <= is_rw && cmd == sdram_refresh_pkg::cmd_write && link.wr_err;
      if (is_rw && link.wr_err) begin
        corrupt_col_q <= link.addr[9:0];
      end
    end
  end

  // flags commands during refresh cycle or exit window
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      protocol_err_q <= 1'b0;
    end else begin
      protocol_err_q <= non_nop && (state_q == sdram_refresh_pkg::st_refresh ||
                        (state_q == sdram_refresh_pkg::st_exit && !is_sre)); // [R7] [R19]
    end
  end
endmodule : sdram_refresh_dev

// ### logic/sdram_refresh_ctrl.sv
// controller end: refresh scheduling and self-refresh sequencing
`timescale 1ns/1ps
module sdram_refresh_ctrl #(
  parameter int unsigned trefi = sdram_refresh_pkg::trefi_cycles
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // user requests
  input wire logic sr_req,
  input wire logic pull_in_req,
  // command link
  sdram_cmd_if.ctrl link,
  // user status
  output logic in_sr_q,
  output logic ref_issued_q,
  output logic signed [4:0] credit_q
);
  initial begin
    if (trefi < 64) $error("trefi too small");
  end
  typedef enum logic [2:0] {
    c_idle = 3'b000, c_ref = 3'b001, c_odt = 3'b011, c_sr = 3'b010, c_exit = 3'b110
  } ctrl_state_e;
  ctrl_state_e st_q;
  logic [15:0] wait_q;
  logic [15:0] tick_q;
  logic [3:0] cmd_q;
  logic cke_q;
  logic need_extra_q;

  // decisions
  wire wait_done = wait_q == 16'h0000;
  wire interval = tick_q == 16'h0000;
  wire must_ref = credit_q <= 5'sd0 && interval || credit_q < -5'sd6; // [R9] [R22]
  wire want_ref = must_ref || (pull_in_req && credit_q < 5'sd8); // [R10]
  wire sr_ok = sr_req && credit_q >= 5'sd0 && !need_extra_q; // [R11] [R20]

  assign link.cs_n = cmd_q[3];
  assign link.ras_n = cmd_q[2];
  assign link.cas_n = cmd_q[1];
  assign link.we_n = cmd_q[0];
  assign link.cke = cke_q;
  assign link.odt = 1'b0; // [R13]
  assign link.addr = 16'h0000;
  assign link.wr_err = 1'b0;

  // interval tick for average refresh rate
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_q <= 16'h0000;
    end else begin
      tick_q <= interval ? 16'(trefi - 1) : tick_q - 16'h0001; // [R8]
    end
  end

  // sequencer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_q <= c_idle;
      wait_q <= 16'h0000;
      cmd_q <= sdram_refresh_pkg::cmd_nop;
      cke_q <= 1'b1;
      credit_q <= 5'sd0;
      need_extra_q <= 1'b0;
      in_sr_q <= 1'b0;
      ref_issued_q <= 1'b0;
    end else begin
      cmd_q <= sdram_refresh_pkg::cmd_nop;
      ref_issued_q <= 1'b0;
      if (!wait_done) wait_q <= wait_q - 16'h0001;
      // credit falls each interval outside self-refresh, floor at postponed limit
      if (interval && st_q != c_sr && credit_q > -5'sd8) credit_q <= credit_q - 5'sd1;
      case (st_q)
        c_idle: begin
          if (wait_done && want_ref) begin
            cmd_q <= sdram_refresh_pkg::cmd_refresh; // [R4] [R5]
            ref_issued_q <= 1'b1;
            credit_q <= (credit_q >= 5'sd8) ? 5'sd8 :
                        credit_q + (interval ? 5'sd0 : 5'sd1);
            need_extra_q <= 1'b0;
            wait_q <= 16'(sdram_refresh_pkg::trfc_cycles); // [R7]
            st_q <= c_ref;
          end else if (wait_done && sr_ok) begin
            wait_q <= 16'(sdram_refresh_pkg::trp_cycles);
            st_q <= c_odt; // [R13]
          end
        end
        c_ref: if (wait_done) st_q <= c_idle;
        c_odt: if (wait_done) begin
          cmd_q <= sdram_refresh_pkg::cmd_refresh; // [R12]
          cke_q <= 1'b0; // [R14]
          wait_q <= 16'(sdram_refresh_pkg::tckesr_cycles);
          in_sr_q <= 1'b1;
          st_q <= c_sr;
        end
        c_sr: if (wait_done && !sr_req) begin
          cke_q <= 1'b1; // [R17] [R18]
          in_sr_q <= 1'b0;
          need_extra_q <= 1'b1;
          wait_q <= 16'(sdram_refresh_pkg::txsdll_cycles); // [R19] [R21]
          st_q <= c_exit;
        end
        default: if (wait_done) st_q <= c_idle;
      endcase
    end
  end
endmodule : sdram_refresh_ctrl

// ### testbench/sdram_link_chk.sv
// wire checker for the refresh command link
`timescale 1ns/1ps
module sdram_link_chk #(
  parameter int unsigned trefi = 100
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // command link
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic [15:0] addr,
  input wire logic wr_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // command decode
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire idle_c = cs_n || cmd == sdram_refresh_pkg::cmd_nop;
  wire ref_c = cmd == sdram_refresh_pkg::cmd_refresh;
  logic cke_q; // cke at the last edge
  wire srx = cke && !cke_q;
  logic seen_q; // refresh seen since exit
  int gap_q; // cycles since a refresh
  int wait_q; // quiet cycles still owed
  int hold_q; // cycles since exit
  // window counters
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cke_q <= 1'b1;
      seen_q <= 1'b1;
      gap_q <= 0;
      wait_q <= 0;
      hold_q <= 600;
    end else begin
      cke_q <= cke;
      seen_q <= srx ? 1'b0 : (seen_q | (ref_c & cke));
      gap_q <= (ref_c | ~cke) ? 0 : gap_q + 1;
      hold_q <= srx ? 0 : (hold_q < 600 ? hold_q + 1 : hold_q);
      wait_q <= (ref_c & cke) ? int'(sdram_refresh_pkg::trfc_cycles) - 1 :
                srx ? int'(sdram_refresh_pkg::txs_cycles) - 1 : (wait_q > 0 ? wait_q - 1 : 0);
    end
  end
  // entry and exit steps
  sequence s_entry;
    cke_q && !cke && ref_c;
  endsequence
  sequence s_exit;
    !cke ##1 (cke && idle_c);
  endsequence
  a_ref_quiet_window: assert property ((wait_q != 0) |-> idle_c)
    else $error("command inside quiet window");
  a_ref_gap_bound: assert property (gap_q <= 9 * int'(trefi))
    else $error("refresh gap too long");
  a_entry_odt_off: assert property (s_entry |-> !odt && !$past(odt))
    else $error("termination on at entry");
  a_entry_cke_hold: assert property (s_entry |=> !cke [*2])
    else $error("cke rose too early");
  a_exit_nop_run: assert property (s_exit |-> idle_c [*8])
    else $error("command during exit");
  a_exit_cke_high: assert property ((hold_q < 512 && cke_q && !cke) |-> ref_c)
    else $error("cke dropped during exit");
  a_reentry_extra_ref: assert property (s_entry |-> seen_q && hold_q >= 13)
    else $error("re-entry without refresh");
  a_ref_after_pre: assert property (ref_c |-> $past(cmd) != sdram_refresh_pkg::cmd_precharge)
    else $error("refresh right after precharge");
endmodule : sdram_link_chk

// ### testbench/tb.sv
// self-checking bench for both link ends
`timescale 1ns/1ps
module tb;
  localparam int unsigned trefi = 100; // shortened interval
  // drive and status
  logic core_clk, reset, sr_req, pull_in_req;
  logic busy_q, in_selfref_q, dll_locked_q, refresh_pulse_q, burst8_q, burst_valid_q;
  logic corrupt_q, protocol_err_q, in_sr_q, ref_issued_q;
  logic [15:0] refresh_row_q;
  logic [9:0] col_q, corrupt_col_q;
  logic signed [4:0] credit_q;
  // bench model state
  int num_errors = 0, tests_run = 0, exp_row = 0, nref = 0, cyc = 0, n, e0;
  bit ref_p, cke_p;
  sdram_cmd_if link ();
  sdram_refresh_ctrl #(.trefi(trefi)) u_sdram_refresh_ctrl (.core_clk(core_clk),
    .reset(reset), .sr_req(sr_req), .pull_in_req(pull_in_req), .link(link),
    .in_sr_q(in_sr_q), .ref_issued_q(ref_issued_q), .credit_q(credit_q));
  sdram_refresh_dev #(.sr_timer(trefi)) u_sdram_refresh_dev (.core_clk(core_clk),
    .reset(reset), .link(link), .busy_q(busy_q), .in_selfref_q(in_selfref_q),
    .dll_locked_q(dll_locked_q), .refresh_row_q(refresh_row_q),
    .refresh_pulse_q(refresh_pulse_q), .burst8_q(burst8_q), .burst_valid_q(burst_valid_q),
    .col_q(col_q), .corrupt_q(corrupt_q), .corrupt_col_q(corrupt_col_q),
    .protocol_err_q(protocol_err_q));
  sdram_link_chk #(.trefi(trefi)) u_sdram_link_chk (.core_clk(core_clk), .reset(reset),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .cke(link.cke), .odt(link.odt), .addr(link.addr), .wr_err(link.wr_err));
  // clock source
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // verdict and stop
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // reset and look at idle outputs
  task automatic reset_dut();
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    check(16'({busy_q, in_selfref_q, dll_locked_q, in_sr_q}), 16'h2);
    check(refresh_row_q, 16'h0);
    check(16'(credit_q), 16'h0);
  endtask : reset_dut
  // link decode model, row model, watchdog
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      end_of_test();
    end
    if (reset) begin
      exp_row = 0;
      ref_p = 0;
    end else begin
      if (ref_p) check(16'(refresh_pulse_q), 16'h1);
      if (refresh_pulse_q === 1'b1) begin
        exp_row++;
        check(refresh_row_q, exp_row[15:0]);
      end
      check(16'({protocol_err_q, corrupt_q, burst_valid_q}), 16'h0);
      check(16'(credit_q > 8 || credit_q < -8), 16'h0);
      ref_p = link.cke && cke_p && {link.cs_n, link.ras_n, link.cas_n, link.we_n} ==
              sdram_refresh_pkg::cmd_refresh;
      if (ref_p) nref++;
    end
    cke_p = link.cke;
  end
  // main sequence
  initial begin
    reset = 1'b1;
    sr_req = 1'b0;
    pull_in_req = 1'b0;
    void'($urandom(23726));
    reset_dut();
    // plain periodic refresh
    repeat (1000) @(posedge core_clk);
    @(negedge core_clk);
    check(16'(nref >= 2 && nref <= 19), 16'h1);
    // pulled-in refresh saturates credit
    @(posedge core_clk);
    pull_in_req <= 1'b1;
    repeat (300 + $urandom % 200) @(posedge core_clk);
    // an interval tick may dip credit until the next pull-in lands
    @(negedge core_clk);
    for (n = 0; n < 40 && credit_q !== 5'sd8; n++) @(negedge core_clk);
    check(16'(credit_q), 16'h8);
    @(posedge core_clk);
    pull_in_req <= 1'b0;
    // enter, stay, leave; second pass requests re-entry at once, entered after the extra refresh
    for (int i = 0; i < 2; i++) begin
      sr_req <= 1'b1;
      for (n = 0; n < 1500 && in_selfref_q !== 1'b1; n++) @(posedge core_clk);
      e0 = exp_row;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check(16'({in_selfref_q, dll_locked_q, in_sr_q}), 16'h5);
      check(16'(exp_row > e0), 16'h1);
      repeat (20 + $urandom % 200) @(posedge core_clk);
      sr_req <= 1'b0;
      for (n = 0; n < 100 && in_selfref_q !== 1'b0; n++) @(posedge core_clk);
      @(negedge core_clk);
      check(16'({in_selfref_q, dll_locked_q}), 16'h0);
      for (n = 0; n < 700 && dll_locked_q !== 1'b1; n++) @(posedge core_clk);
      @(negedge core_clk);
      check(16'(dll_locked_q), 16'h1);
      @(posedge core_clk);
    end
    reset_dut();
    end_of_test();
  end
endmodule : tb
